/* design/icm_mode_control.sv */
`timescale 1ns/10ps
// Functional notes
// (R1) single repeats one channel; multi cycles enabled
// (R2) irq per conversion, or per full sequence
// (R3) per-channel 16-bit reference count sets interval
// (R4) per-channel settle count before measuring
// (R5) per-channel reference and sensor dividers
// (R6) reference from internal clock or external input
// (R7) per-channel drive current field
// (R8) auto override picks and adjusts drive itself
// (R9) report amplitude, no-oscillation, new data, errors
// (R10) power-up into sleep, no conversions
// (R11) sleep-enable 1 sleeps, 0 converts
// (R12) wait 16384 internal periods after wake
// (R13) sleep keeps access, clears results, irq high
// (R14) shutdown pin high shuts down, low sleeps
// (R15) shutdown resets registers, stops, irq high
// (R16) no register access during shutdown
// (R17) host changes address pin only in shutdown
// (R18) software reset stops and restores defaults
// (R19) host configures only while sleeping
// (R20) host reads results during normal mode
// (R21) upper word read loads both result words
// (R22) address 0x2a or 0x2b by select pin
// (R23) multi sequence ascending, wraps to lowest
module icm_mode_control
  import icm_pkg::*;
#(
  parameter int NCH = NUM_CH,
  parameter int CW = (NCH > 1) ? $clog2(NCH) : 1,
  parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic shutdownPin,
  input wire logic addrSelPin,
  input wire logic extRefClockIn,
  input wire logic sensorEdgeIn,
  input wire logic ampHighIn,
  input wire logic ampLowIn,
  input wire logic sleepEnableWr,
  input wire logic sleepEnableVal,
  input wire logic softwareResetWr,
  input wire logic statusReadAck,
  input wire logic singleChannelMode,
  input wire logic [CW-1:0] activeChannel,
  input wire logic [NCH-1:0] chanEnable,
  input wire logic irqEnable,
  input wire logic extRefSelect,
  input wire logic [NCH-1:0][COUNT_W-1:0] refCountSetting,
  input wire logic [NCH-1:0][COUNT_W-1:0] settleCountSetting,
  input wire logic [NCH-1:0][REF_DIV_W-1:0] refDivider,
  input wire logic [NCH-1:0][SENS_DIV_W-1:0] sensorDivider,
  input wire logic [NCH-1:0][DRIVE_W-1:0] driveCurrentField,
  input wire logic autoDriveOverrideEnable,
  input wire logic resultReadMsb,
  input wire logic [CW-1:0] resultReadChan,
  output logic irqNOut,
  output logic sleepEnableRead,
  output logic softwareResetRead,
  output logic regDefaultsReq,
  output logic i2cAccessEnable,
  output logic [6:0] i2cAddress,
  output logic [CW-1:0] curChannel,
  output logic convActive,
  output logic [DRIVE_W-1:0] driveCurrentOut,
  output logic [FLAG_W-1:0] statusFlags,
  output logic [NCH-1:0] dataReady,
  output logic [WORD_W-1:0] resultMsbWord,
  output logic [WORD_W-1:0] resultLsbWord
);

  function automatic logic [CW-1:0] nextEnabled(
    input logic [NCH-1:0] en,
    input logic [CW-1:0] cur
  );
    logic [CW-1:0] pick;
    logic found;
    pick = cur;
    found = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (en[i] && i > int'(cur)) begin
        pick = CW'(i);
        found = 1'b1;
      end
    end
    if (!found) begin
      for (int i = NCH - 1; i >= 0; i--) begin
        if (en[i]) begin
          pick = CW'(i);
        end
      end
    end
    return pick;
  endfunction

  // a zero count still waits one divided reference tick, not a 16-tick unit
  function automatic logic [TIMER_W-1:0] scaled(input logic [COUNT_W-1:0] c);
    return (c == '0) ? TIMER_W'(1) : {c, {TICK_SHIFT{1'b0}}};
  endfunction

  localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_CYCLES - 1);
  localparam logic [RESULT_W-1:0] ACC_MAX = '1;

  // pin synchronisers: bit0 shutdown, 1 addr, 2 ext ref, 3 sensor, 4-5 amp
  logic [5:0] syncA_ff, syncB_ff;
  logic extPrev_ff, sensPrev_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      extPrev_ff <= 1'b0;
      sensPrev_ff <= 1'b0;
    end else begin
      syncA_ff <= {ampLowIn, ampHighIn, sensorEdgeIn, extRefClockIn,
                   addrSelPin, shutdownPin};
      syncB_ff <= syncA_ff;
      extPrev_ff <= syncB_ff[2];
      sensPrev_ff <= syncB_ff[3];
    end
  end

  icm_mode_t modeFf, nxtMode;
  logic [CW-1:0] curChan_ff, nxtChan;
  logic [TIMER_W-1:0] timer_ff, nxtTimer;
  logic [WAKE_W-1:0] wakeCnt_ff, nxtWake;
  logic [REF_DIV_W-1:0] refDivCnt_ff, nxtRefDiv, refLim;
  logic [SENS_DIV_W-1:0] sensDivCnt_ff, nxtSensDiv, sensLim;
  logic [RESULT_W-1:0] accum_ff, nxtAccum;
  logic sleepEn_ff, nxtSleepEn, irqN_ff, nxtIrqN;
  logic [NCH-1:0] dataReady_ff, nxtReady, valid_ff, nxtValid;
  logic [FLAG_W-1:0] flags_ff, nxtFlags;
  logic [DRIVE_W-1:0] drive_ff, nxtDrive;
  logic [NCH-1:0][DRIVE_W-1:0] autoDrive_ff, nxtAuto;
  logic defaults_ff, nxtDefaults, i2cEn_ff, nxtI2cEn;
  logic [6:0] addr_ff, nxtAddr;
  logic addrCaught_ff, nxtAddrCaught;
  logic refTick, divTick, sensEdge, sensTick, convEnd, doClear, readTake;
  logic memWr, conv_ff, nxtConv, rstRead_ff;

  icm_mem_if #(.AW(CW), .DW(RESULT_W)) memBus ();

  // flags: [3] conversion error, [2] no oscillation, [1] amp high, [0] low
  always_comb begin
    nxtMode = modeFf;
    nxtChan = curChan_ff;
    nxtTimer = timer_ff;
    nxtWake = wakeCnt_ff;
    nxtRefDiv = refDivCnt_ff;
    nxtSensDiv = sensDivCnt_ff;
    nxtAccum = accum_ff;
    nxtSleepEn = sleepEn_ff;
    nxtIrqN = irqN_ff;
    nxtReady = dataReady_ff;
    nxtValid = valid_ff;
    nxtFlags = flags_ff;
    nxtAuto = autoDrive_ff;
    nxtDefaults = 1'b0;
    convEnd = 1'b0;
    memWr = 1'b0;
    readTake = resultReadMsb && i2cEn_ff;
    refTick = !extRefSelect || (syncB_ff[2] && !extPrev_ff); // [R6]
    refLim = (refDivider[curChan_ff] == '0) ? '0 :
             refDivider[curChan_ff] - REF_DIV_W'(1);
    sensLim = (sensorDivider[curChan_ff] == '0) ? '0 :
              sensorDivider[curChan_ff] - SENS_DIV_W'(1);
    divTick = refTick && (refDivCnt_ff >= refLim); // [R5]
    sensEdge = syncB_ff[3] && !sensPrev_ff;
    sensTick = sensEdge && (sensDivCnt_ff >= sensLim); // [R5]
    // clears go first so a same-cycle event still sets its flag
    if (statusReadAck) begin
      nxtIrqN = 1'b1;
      nxtFlags = '0;
    end
    if (readTake) begin
      nxtReady[resultReadChan] = 1'b0;
    end
    if (refTick && (modeFf == MD_SETTLE || modeFf == MD_CONVERT)) begin
      nxtRefDiv = divTick ? '0 : refDivCnt_ff + REF_DIV_W'(1);
    end
    unique case (modeFf)
      MD_SHUTDOWN: begin
        nxtMode = MD_SHUTDOWN;
      end
      MD_SLEEP: begin
        if (!sleepEn_ff) begin // [R11]
          nxtMode = MD_WAKE;
          nxtWake = WAKE_LOAD; // [R12]
        end
      end
      MD_WAKE: begin
        if (wakeCnt_ff == '0) begin // [R12]
          nxtMode = MD_SETTLE;
          nxtChan = singleChannelMode ? activeChannel :
                    nextEnabled(chanEnable, CW'(NCH - 1)); // [R23]
          nxtTimer = scaled(settleCountSetting[nxtChan]); // [R4]
          nxtRefDiv = '0;
        end else begin
          nxtWake = wakeCnt_ff - WAKE_W'(1);
        end
      end
      MD_SETTLE: begin
        if (divTick) begin
          if (timer_ff <= TIMER_W'(1)) begin
            nxtMode = MD_CONVERT;
            nxtTimer = scaled(refCountSetting[curChan_ff]); // [R3]
            nxtAccum = '0;
            nxtSensDiv = '0;
          end else begin
            nxtTimer = timer_ff - TIMER_W'(1); // [R4]
          end
        end
      end
      MD_CONVERT: begin
        if (sensTick) begin
          nxtSensDiv = '0;
          if (accum_ff == ACC_MAX) begin
            nxtFlags[3] = 1'b1; // [R9]
          end else begin
            nxtAccum = accum_ff + RESULT_W'(1);
          end
        end else if (sensEdge) begin
          nxtSensDiv = sensDivCnt_ff + SENS_DIV_W'(1);
        end
        if (divTick) begin
          if (timer_ff <= TIMER_W'(1)) begin
            convEnd = 1'b1;
          end else begin
            nxtTimer = timer_ff - TIMER_W'(1); // [R3]
          end
        end
      end
    endcase
    if (convEnd) begin
      memWr = 1'b1;
      nxtReady[curChan_ff] = 1'b1; // [R9]
      nxtValid[curChan_ff] = 1'b1;
      nxtFlags = nxtFlags | {1'b0, accum_ff == '0, syncB_ff[4],
                             syncB_ff[5]}; // [R9]
      if (syncB_ff[5] && autoDrive_ff[curChan_ff] != DRIVE_MAX) begin
        nxtAuto[curChan_ff] = autoDrive_ff[curChan_ff] + DRIVE_W'(1); // [R8]
      end else if (syncB_ff[4] && autoDrive_ff[curChan_ff] != '0) begin
        nxtAuto[curChan_ff] = autoDrive_ff[curChan_ff] - DRIVE_W'(1); // [R8]
      end
      if (irqEnable && (singleChannelMode ||
          nextEnabled(chanEnable, curChan_ff) <= curChan_ff)) begin
        nxtIrqN = 1'b0; // [R2]
      end
      nxtChan = singleChannelMode ? activeChannel :
                nextEnabled(chanEnable, curChan_ff); // [R1] [R23]
      nxtMode = MD_SETTLE;
      nxtTimer = scaled(settleCountSetting[nxtChan]);
      nxtRefDiv = '0;
    end
    if (sleepEnableWr && i2cEn_ff) begin
      nxtSleepEn = sleepEnableVal; // [R11]
    end
    if (sleepEn_ff && modeFf != MD_SHUTDOWN) begin
      nxtMode = MD_SLEEP; // [R11]
    end
    if (softwareResetWr && i2cEn_ff) begin
      nxtMode = MD_SLEEP; // [R18]
      nxtSleepEn = 1'b1;
      nxtDefaults = 1'b1;
      nxtAuto = {NCH{DRIVE_AUTO_START}};
    end
    if (syncB_ff[0]) begin
      nxtMode = MD_SHUTDOWN; // [R14]
      nxtSleepEn = 1'b1;
      nxtDefaults = 1'b1; // [R15]
      nxtAuto = {NCH{DRIVE_AUTO_START}};
    end else if (modeFf == MD_SHUTDOWN) begin
      nxtMode = MD_SLEEP; // [R14]
    end
    // nothing converts in sleep or shutdown, so clear every cycle there
    doClear = (nxtMode == MD_SLEEP) || (nxtMode == MD_SHUTDOWN);
    if (doClear) begin
      nxtReady = '0; // [R13] [R15]
      nxtValid = '0;
      nxtFlags = '0;
      nxtIrqN = 1'b1;
      nxtAccum = '0;
    end
    nxtDrive = autoDriveOverrideEnable ? nxtAuto[nxtChan] :
               driveCurrentField[nxtChan]; // [R7] [R8]
    nxtI2cEn = (nxtMode != MD_SHUTDOWN); // [R16]
    nxtConv = (nxtMode == MD_CONVERT);
    nxtAddrCaught = 1'b1;
    nxtAddr = addr_ff;
    if (!addrCaught_ff || modeFf == MD_SHUTDOWN) begin
      nxtAddr = syncB_ff[1] ? I2C_ADDR_HIGH : I2C_ADDR_LOW; // [R22]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeFf <= MD_SLEEP; // [R10]
      curChan_ff <= '0;
      timer_ff <= '0;
      wakeCnt_ff <= '0;
      refDivCnt_ff <= '0;
      sensDivCnt_ff <= '0;
      accum_ff <= '0;
      sleepEn_ff <= 1'b1; // [R10]
      irqN_ff <= 1'b1;
      dataReady_ff <= '0;
      valid_ff <= '0;
      flags_ff <= '0;
      drive_ff <= '0;
      autoDrive_ff <= {NCH{DRIVE_AUTO_START}};
      defaults_ff <= 1'b0;
      i2cEn_ff <= 1'b1;
      addr_ff <= I2C_ADDR_LOW;
      addrCaught_ff <= 1'b0;
      conv_ff <= 1'b0;
      rstRead_ff <= 1'b0;
    end else begin
      modeFf <= nxtMode;
      curChan_ff <= nxtChan;
      timer_ff <= nxtTimer;
      wakeCnt_ff <= nxtWake;
      refDivCnt_ff <= nxtRefDiv;
      sensDivCnt_ff <= nxtSensDiv;
      accum_ff <= nxtAccum;
      sleepEn_ff <= nxtSleepEn;
      irqN_ff <= nxtIrqN;
      dataReady_ff <= nxtReady;
      valid_ff <= nxtValid;
      flags_ff <= nxtFlags;
      drive_ff <= nxtDrive;
      autoDrive_ff <= nxtAuto;
      defaults_ff <= nxtDefaults;
      i2cEn_ff <= nxtI2cEn;
      addr_ff <= nxtAddr;
      addrCaught_ff <= nxtAddrCaught;
      conv_ff <= nxtConv;
      // the reset bit is write-only; its readback is a fixed zero
      rstRead_ff <= 1'b0; // [R18]
    end
  end

  // result readback: upper-word read snapshots both words
  logic [WORD_W-1:0] msb_ff, nxtMsb, lsb_ff, nxtLsb;
  logic rdPend_ff, nxtRdPend;
  logic [CW-1:0] rdChan_ff, nxtRdChan;

  assign memBus.wrEn = memWr;
  assign memBus.wrAddr = curChan_ff;
  assign memBus.wrData = accum_ff;
  assign memBus.rdEn = readTake;
  assign memBus.rdAddr = resultReadChan;

  always_comb begin
    nxtRdPend = readTake;
    nxtRdChan = readTake ? resultReadChan : rdChan_ff;
    nxtMsb = msb_ff;
    nxtLsb = lsb_ff;
    if (rdPend_ff) begin
      nxtMsb = valid_ff[rdChan_ff] ?
               {flags_ff, memBus.rdData[RESULT_W-1:WORD_W]} : '0; // [R21]
      nxtLsb = valid_ff[rdChan_ff] ?
               memBus.rdData[WORD_W-1:0] : '0; // [R21]
    end
    if (doClear) begin
      nxtMsb = '0; // [R13]
      nxtLsb = '0;
      nxtRdPend = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msb_ff <= '0;
      lsb_ff <= '0;
      rdPend_ff <= 1'b0;
      rdChan_ff <= '0;
    end else begin
      msb_ff <= nxtMsb;
      lsb_ff <= nxtLsb;
      rdPend_ff <= nxtRdPend;
      rdChan_ff <= nxtRdChan;
    end
  end

  icm_result_mem #(.DEPTH(NCH), .WIDTH(RESULT_W), .AW(CW)) u_mem (
    .clk(clk),
    .rst(rst),
    .port(memBus.store)
  );

  assign irqNOut = irqN_ff;
  assign sleepEnableRead = sleepEn_ff;
  assign softwareResetRead = rstRead_ff; // [R18]
  assign regDefaultsReq = defaults_ff;
  assign i2cAccessEnable = i2cEn_ff;
  assign i2cAddress = addr_ff;
  assign curChannel = curChan_ff;
  assign convActive = conv_ff;
  assign driveCurrentOut = drive_ff;
  assign statusFlags = flags_ff;
  assign dataReady = dataReady_ff;
  assign resultMsbWord = msb_ff;
  assign resultLsbWord = lsb_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_sleep_irq_high: assert property ( // [R13]
    modeFf == MD_SLEEP |-> irqN_ff && dataReady_ff == '0 && msb_ff == '0)
    else $error("sleep mode left irq or results set");
  a_shutdown_no_access: assert property ( // [R16]
    modeFf == MD_SHUTDOWN |-> !i2cEn_ff)
    else $error("register access open during shutdown");
  a_shutdown_entry: assert property ( // [R14]
    syncB_ff[0] |=> modeFf == MD_SHUTDOWN && defaults_ff && irqN_ff)
    else $error("shutdown pin did not shut the block down");
  a_shutdown_exit: assert property ( // [R14]
    modeFf == MD_SHUTDOWN && !syncB_ff[0] |=> modeFf == MD_SLEEP)
    else $error("shutdown release did not return to sleep");
  a_wake_start: assert property ( // [R12]
    modeFf == MD_WAKE && $past(modeFf) == MD_SLEEP |->
      wakeCnt_ff == WAKE_LOAD)
    else $error("wake delay loaded with wrong count");
  a_wake_no_early: assert property ( // [R12]
    modeFf == MD_WAKE && wakeCnt_ff != '0 |=> modeFf != MD_SETTLE)
    else $error("conversion started before wake delay ran out");
  a_soft_reset: assert property ( // [R18]
    softwareResetWr && i2cEn_ff && !syncB_ff[0] |=>
      modeFf == MD_SLEEP && defaults_ff && sleepEn_ff)
    else $error("software reset did not stop and restore");
  a_single_chan: assert property ( // [R1]
    convEnd && singleChannelMode && modeFf == MD_CONVERT && !sleepEn_ff &&
      !syncB_ff[0] && !softwareResetWr |=> curChan_ff == $past(activeChannel))
    else $error("single mode moved off the chosen channel");
  a_irq_multi: assert property ( // [R2]
    $fell(irqN_ff) |-> $past(singleChannelMode) ||
      nextEnabled($past(chanEnable), $past(curChan_ff)) <= $past(curChan_ff))
    else $error("irq asserted before the sequence completed");
  a_addr_select: assert property ( // [R22]
    modeFf == MD_SHUTDOWN |=>
      addr_ff == ($past(syncB_ff[1]) ? I2C_ADDR_HIGH : I2C_ADDR_LOW))
    else $error("address not taken from the select pin in shutdown");

endmodule

/* design/icm_pkg.sv */
package icm_pkg;

  localparam int NUM_CH = 4;
  localparam int COUNT_W = 16;
  localparam int REF_DIV_W = 10;
  localparam int SENS_DIV_W = 4;
  localparam int DRIVE_W = 5;
  localparam int RESULT_W = 28;
  localparam int TICK_SHIFT = 4;
  localparam int TIMER_W = COUNT_W + TICK_SHIFT;
  localparam int WORD_W = 16;
  localparam int FLAG_W = 4;
  localparam int MSB_DATA_W = RESULT_W - WORD_W;

  localparam logic [DRIVE_W-1:0] DRIVE_MAX = 5'h1f;
  localparam logic [DRIVE_W-1:0] DRIVE_AUTO_START = 5'h0f;

  localparam logic [6:0] I2C_ADDR_LOW = 7'h2a;
  localparam logic [6:0] I2C_ADDR_HIGH = 7'h2b;

  // wake delay is given in internal-oscillator periods and counted in clk cycles
  localparam longint CLK_KHZ = 100000;
  localparam longint INT_OSC_KHZ = 43000;
  localparam longint WAKE_INT_PERIODS = 16384;
  localparam int WAKE_CYCLES_DEF =
    int'((WAKE_INT_PERIODS * CLK_KHZ + INT_OSC_KHZ - 1) / INT_OSC_KHZ);
  localparam int WAKE_W = 17;

  typedef enum logic [2:0] {
    MD_SHUTDOWN,
    MD_SLEEP,
    MD_WAKE,
    MD_SETTLE,
    MD_CONVERT
  } icm_mode_t;

endpackage

/* design/icm_mem_if.sv */
`timescale 1ns/10ps
interface icm_mem_if #(
  parameter int AW = 2,
  parameter int DW = 28
) ();
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic rdEn;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;

  modport ctrl(output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
  modport store(input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
endinterface

/* design/icm_result_mem.sv */
`timescale 1ns/10ps
module icm_result_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 28,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic rst,
  icm_mem_if.store port
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdData_ff;
  logic [WIDTH-1:0] nxt_rdData;

  // storage has no reset; the controller masks never-written entries
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      mem[port.wrAddr] <= port.wrData;
    end
  end

  always_comb begin
    nxt_rdData = rdData_ff;
    if (port.rdEn) begin
      nxt_rdData = mem[port.rdAddr];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign port.rdData = rdData_ff;
endmodule

/* verif/icm_sensor_model.sv */
`timescale 1ns/10ps
// sensor front end and external reference oscillator; both run free, the
// sensor at an 80 ns period locked to clk, the reference with a phase unrelated to clk
module icm_sensor_model (
  input wire logic ampLowReq,
  input wire logic ampHighReq,
  output logic sensorEdgeIn,
  output logic extRefClockIn,
  output logic ampHighIn,
  output logic ampLowIn
);
  initial begin
    sensorEdgeIn = 1'b0;
    forever #40 sensorEdgeIn = ~sensorEdgeIn;
  end

  // 34 ns period, deliberately not a multiple of the 10 ns core clock
  initial begin
    extRefClockIn = 1'b0;
    #3;
    forever #17 extRefClockIn = ~extRefClockIn;
  end

  assign ampLowIn = ampLowReq;
  assign ampHighIn = ampHighReq;
endmodule

/* verif/inductive_converter_mode_control_bench.sv */
`timescale 1ns/10ps
module inductive_converter_mode_control_bench;
  import icm_pkg::*;
  localparam int WAKE = 20;
  logic clk, rst, shutdownPin, addrSelPin, extRefClockIn, sensorEdgeIn;
  logic ampHighIn, ampLowIn, sleepEnableWr, sleepEnableVal, softwareResetWr;
  logic statusReadAck, singleChannelMode, irqEnable, extRefSelect;
  logic autoDriveOverrideEnable, resultReadMsb, ampLowReq, ampHighReq;
  logic [1:0] activeChannel, resultReadChan, curChannel;
  logic [NUM_CH-1:0] chanEnable, dataReady;
  logic [NUM_CH-1:0][COUNT_W-1:0] refCountSetting, settleCountSetting;
  logic [NUM_CH-1:0][REF_DIV_W-1:0] refDivider;
  logic [NUM_CH-1:0][SENS_DIV_W-1:0] sensorDivider;
  logic [NUM_CH-1:0][DRIVE_W-1:0] driveCurrentField;
  logic irqNOut, sleepEnableRead, softwareResetRead, regDefaultsReq;
  logic i2cAccessEnable, convActive;
  logic [6:0] i2cAddress;
  logic [DRIVE_W-1:0] driveCurrentOut;
  logic [FLAG_W-1:0] statusFlags;
  logic [WORD_W-1:0] resultMsbWord, resultLsbWord;
  logic [RESULT_W-1:0] res;
  int n_mismatch = 0;
  int comparisons = 0;
  int nDefaults = 0;
  int nDefBefore;
  int cfgTab [4][5] = '{'{2, 1, 1, 3, 5}, '{4, 1, 1, 7, 9},
                        '{4, 1, 2, 3, 5}, '{2, 2, 1, 7, 9}};
  int seqTab [4] = '{0, 1, 3, 0};

  icm_mode_control #(.WAKE_CYCLES(WAKE)) DUT (
    .clk, .rst, .shutdownPin, .addrSelPin, .extRefClockIn, .sensorEdgeIn,
    .ampHighIn, .ampLowIn, .sleepEnableWr, .sleepEnableVal,
    .softwareResetWr, .statusReadAck, .singleChannelMode, .activeChannel,
    .chanEnable, .irqEnable, .extRefSelect, .refCountSetting,
    .settleCountSetting, .refDivider, .sensorDivider, .driveCurrentField,
    .autoDriveOverrideEnable, .resultReadMsb, .resultReadChan, .irqNOut,
    .sleepEnableRead, .softwareResetRead, .regDefaultsReq, .i2cAccessEnable,
    .i2cAddress, .curChannel, .convActive, .driveCurrentOut, .statusFlags,
    .dataReady, .resultMsbWord, .resultLsbWord
  );

  icm_sensor_model model (
    .ampLowReq(ampLowReq), .ampHighReq(ampHighReq),
    .sensorEdgeIn(sensorEdgeIn), .extRefClockIn(extRefClockIn),
    .ampHighIn(ampHighIn), .ampLowIn(ampLowIn)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a one-cycle strobe is easy to miss from the negedge, so count it
  always @(posedge clk) begin
    if (regDefaultsReq === 1'b1) begin
      nDefaults <= nDefaults + 1;
    end
  end

  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr_sleep(logic v);
    sleepEnableVal = v;
    sleepEnableWr = 1'b1;
    tick(1);
    sleepEnableWr = 1'b0;
  endtask

  task automatic pulse_ack();
    statusReadAck = 1'b1;
    tick(1);
    statusReadAck = 1'b0;
  endtask

  task automatic rd_msb(logic [1:0] ch);
    resultReadChan = ch;
    resultReadMsb = 1'b1;
    tick(1);
    resultReadMsb = 1'b0;
  endtask

  task automatic wait_conv(logic lv);
    for (int i = 0; i < 3000 && convActive !== lv; i++) tick(1);
    check("conv_active_wait", lv, convActive);
  endtask

  task automatic wait_ready(int ch);
    for (int i = 0; i < 3000 && dataReady[ch] !== 1'b1; i++) tick(1);
    check("data_ready_wait", 1, dataReady[ch]);
  endtask

  task automatic cfg(logic single, int ch, logic [3:0] en, int rc, int rd,
                     int sd);
    singleChannelMode = single;
    activeChannel = ch[1:0];
    chanEnable = en;
    for (int i = 0; i < NUM_CH; i++) begin
      refCountSetting[i] = rc[COUNT_W-1:0];
      settleCountSetting[i] = 16'h0001;
      refDivider[i] = rd[REF_DIV_W-1:0];
      sensorDivider[i] = sd[SENS_DIV_W-1:0];
    end
  endtask

  initial begin
    rst = 1'b1;
    {shutdownPin, addrSelPin, sleepEnableWr, sleepEnableVal} = '0;
    {softwareResetWr, statusReadAck, resultReadMsb, extRefSelect} = '0;
    {ampLowReq, ampHighReq, autoDriveOverrideEnable} = '0;
    irqEnable = 1'b1;
    resultReadChan = 2'h0;
    driveCurrentField = '0;
    cfg(1'b1, 2, 4'h0, 2, 1, 1);
    tick(16);
    rst = 1'b0;
    tick(100);
    check("sleep_after_reset", 1, sleepEnableRead);
    check("no_conv_in_sleep", 0, convActive);
    check("no_data_in_sleep", 0, dataReady);
    check("irq_idle", 1, irqNOut);
    check("reset_bit_read", 0, softwareResetRead);
    check("addr_pin_low", 7'h2a, i2cAddress);
    // single channel 2, each divider and count setting in turn
    foreach (cfgTab[k]) begin
      wr_sleep(1'b1);
      tick(4);
      check("sleep_irq_high", 1, irqNOut);
      check("sleep_clears_data", 0, dataReady);
      check("sleep_clears_flags", 0, statusFlags);
      check("sleep_keeps_access", 1, i2cAccessEnable);
      cfg(1'b1, 2, 4'h0, cfgTab[k][0], cfgTab[k][1], cfgTab[k][2]);
      wr_sleep(1'b0);
      tick(1);
      check("sleep_readback", 0, sleepEnableRead);
      // without the wake delay this point would already be converting
      tick(WAKE + 14);
      check("wake_wait", 0, convActive);
      tick(3);
      check("wake_then_conv", cfgTab[k][1] == 1, convActive);
      wait_ready(2);
      check("single_channel", 2, curChannel);
      tick(1);
      check("irq_per_conv", 0, irqNOut);
      rd_msb(2'h2);
      tick(1);
      check("read_clears_ready", 0, dataReady[2]);
      tick(1);
      res = {resultMsbWord[MSB_DATA_W-1:0], resultLsbWord};
      check("result_low", 1, res >= cfgTab[k][3]);
      check("result_high", 1, res <= cfgTab[k][4]);
      pulse_ack();
      check("ack_clears_irq", 1, irqNOut);
    end
    // manual drive code with irq off, then automatic drive on external ref
    wr_sleep(1'b1);
    tick(4);
    irqEnable = 1'b0;
    driveCurrentField[1] = 5'h07;
    cfg(1'b1, 1, 4'h0, 2, 1, 1);
    wr_sleep(1'b0);
    wait_conv(1'b1);
    check("manual_drive", 5'h07, driveCurrentOut);
    wait_ready(1);
    tick(1);
    check("irq_disabled", 1, irqNOut);
    wr_sleep(1'b1);
    tick(4);
    irqEnable = 1'b1;
    autoDriveOverrideEnable = 1'b1;
    extRefSelect = 1'b1;
    ampLowReq = 1'b1;
    wr_sleep(1'b0);
    wait_ready(1);
    tick(2);
    check("auto_drive_step", DRIVE_AUTO_START + 5'h01,
          driveCurrentOut);
    check("amp_low_flag", 1, statusFlags[0]);
    ampLowReq = 1'b0;
    ampHighReq = 1'b1;
    rd_msb(2'h1);
    pulse_ack();
    wait_ready(1);
    tick(2);
    check("auto_drive_back", DRIVE_AUTO_START, driveCurrentOut);
    check("amp_high_flag", 1, statusFlags[1]);
    // multi channel sequence over channels 0, 1 and 3
    wr_sleep(1'b1);
    tick(4);
    {autoDriveOverrideEnable, extRefSelect, ampLowReq, ampHighReq} = '0;
    cfg(1'b0, 0, 4'b1011, 1, 1, 1);
    wr_sleep(1'b0);
    foreach (seqTab[k]) begin
      wait_conv(1'b1);
      check("multi_order", seqTab[k], curChannel);
      wait_conv(1'b0);
      tick(2);
      check("irq_after_all", seqTab[k] != 3, irqNOut);
      if (seqTab[k] == 3) begin
        pulse_ack();
      end
    end
    // software reset in the middle of a conversion
    wait_conv(1'b1);
    nDefBefore = nDefaults;
    softwareResetWr = 1'b1;
    tick(1);
    softwareResetWr = 1'b0;
    tick(4);
    check("soft_reset_defaults", 1, nDefaults == nDefBefore + 1);
    check("soft_reset_stops", 0, convActive);
    check("soft_reset_sleep", 1, sleepEnableRead);
    check("reset_bit_read", 0, softwareResetRead);
    // shutdown while converting; address pin moved only in shutdown
    cfg(1'b1, 0, 4'h0, 2, 1, 1);
    wr_sleep(1'b0);
    wait_conv(1'b1);
    shutdownPin = 1'b1;
    // the pin needs two sync stages and one edge before shutdown holds
    tick(4);
    addrSelPin = 1'b1;
    tick(4);
    check("sd_no_access", 0, i2cAccessEnable);
    check("sd_irq_high", 1, irqNOut);
    check("sd_stops", 0, convActive);
    check("sd_clears_data", 0, dataReady);
    check("sd_clears_flags", 0, statusFlags);
    check("sd_defaults", 1, regDefaultsReq);
    wr_sleep(1'b0);
    tick(WAKE + 60);
    check("sd_ignores_write", 0, convActive);
    shutdownPin = 1'b0;
    tick(60);
    check("sd_exit_access", 1, i2cAccessEnable);
    check("sd_exit_sleep", 1, sleepEnableRead);
    check("sd_exit_no_conv", 0, convActive);
    check("addr_pin_high", 7'h2b, i2cAddress);
    test_done();
  end

  // the full sequence needs roughly 1,400 cycles
  initial begin
    #200us;
    n_mismatch++;
    test_done();
  end
endmodule
